// ==== hw/scan_reg.sv ====
// pipeline register with serial shadow scan register
// Operation
// - two separate 8-bit registers: pipeline and shadow
// - mode low: diag_clk rise shifts shadow up, bit 0 from scan_in
// - mode low: pipe_clk rise loads pipeline from data pins
// - mode high, scan_in low: diag_clk rise captures outputs; scan_out low
// - mode high, scan_in high: shadow holds; data pins driven; scan_out high
// - mode high: pipe_clk rise loads pipeline from shadow; scan_out follows scan_in
// - pipeline input muxed from pins or shadow, loaded only on pipe_clk
// - clocks independent; simultaneous swap uses each register's prior value
`timescale 1ns/1ps
`default_nettype none
`include "scan_reg_map.svh"
module scan_reg #(
  parameter int WIDTH = `SCAN_WIDTH
) (
  input  wire logic             clk,       // system clock, 100 MHz
  input  wire logic             rst_b,     // async reset, active low
  input  wire logic             pipe_clk,  // pipeline clock pin
  input  wire logic             diag_clk,  // diagnostic clock pin
  input  wire logic             mode,      // diagnostic mode select
  input  wire logic             scan_in,   // serial scan input
  output logic                  scan_out,  // serial scan output
  input  wire logic [WIDTH-1:0] d_in,      // parallel data pins, input side
  output logic      [WIDTH-1:0] d_out,     // parallel data pins, output side
  output logic                  d_oe,      // data pin output enable
  output logic      [WIDTH-1:0] y_out      // pipeline outputs
);
  logic             pclk_rise;
  logic             diag_clk_rise;
  logic             mode_s;
  logic             sin_s;
  logic [WIDTH-1:0] d_meta_q;
  logic [WIDTH-1:0] d_sync_q;
  logic [WIDTH-1:0] pipe_q;
  logic [WIDTH-1:0] pipe_d;
  logic [WIDTH-1:0] shadow_q;
  logic [WIDTH-1:0] shadow_d;
  logic             sout_q;
  scan_reg_pkg::diag_op_t op;

  // clock pins are sampled, edges found in the system domain
  // an edge acts three clk later; pulses under one clk wide may be lost
  edge_sync u_pclk (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (pipe_clk),
    .level (),
    .rise  (pclk_rise)
  );

  edge_sync u_diag_clk (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (diag_clk),
    .level (),
    .rise  (diag_clk_rise)
  );

  edge_sync u_mode (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (mode),
    .level (mode_s),
    .rise  ()
  );

  edge_sync u_sin (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (scan_in),
    .level (sin_s),
    .rise  ()
  );

  // data pins take the same two-flop delay as the clocks, keeping alignment
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_meta_q <= '0;
      d_sync_q <= '0;
    end else begin
      d_meta_q <= d_in;
      d_sync_q <= d_meta_q;
    end
  end

  // mode and scan_in are synced, so the operation never changes mid-cycle
  always_comb begin
    if (!mode_s)
      op = scan_reg_pkg::OP_SHIFT;
    else if (!sin_s)
      op = scan_reg_pkg::OP_CAPTURE;
    else
      op = scan_reg_pkg::OP_HOLD;
  end

  // pipeline source mux
  assign pipe_d = mode_s ? shadow_q : d_sync_q;

  // zero at reset keeps outputs defined; the pins give no power-up value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      pipe_q <= `DATA_RESET;
    else if (pclk_rise)
      pipe_q <= pipe_d;
  end

  always_comb begin
    shadow_d = shadow_q;
    unique case (op)
      scan_reg_pkg::OP_SHIFT:   shadow_d = {shadow_q[WIDTH-2:0], sin_s};
      scan_reg_pkg::OP_CAPTURE: shadow_d = pipe_q;
      scan_reg_pkg::OP_HOLD:    shadow_d = shadow_q;
      // spare code is never decoded; holding is the safe choice
      default:                  shadow_d = shadow_q;
    endcase
  end

  // both registers read prior values, so a same-cycle swap works
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      shadow_q <= `DATA_RESET;
    else if (diag_clk_rise)
      shadow_q <= shadow_d;
  end

  // mode low shows top bit; mode high follows scan_in (low or high)
  // registered so scan_out cannot glitch while the synced inputs settle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      sout_q <= 1'b0;
    else
      sout_q <= mode_s ? sin_s : shadow_d[WIDTH-1];
  end

  // pins are driven only while the shadow is held
  assign scan_out = mode_s ? sout_q : shadow_q[WIDTH-1];
  assign d_oe     = (op == scan_reg_pkg::OP_HOLD);
  assign d_out    = shadow_q;
  assign y_out    = pipe_q;

  // shadow path
  AST_SHIFT: assert property (@(posedge clk) disable iff (!rst_b)
    (diag_clk_rise && !mode_s) |=> shadow_q == {$past(shadow_q[WIDTH-2:0]), $past(sin_s)})
    else $error("shadow did not shift");

  AST_SHIFT_OUT: assert property (@(posedge clk) disable iff (!rst_b)
    (diag_clk_rise && !mode_s) |=> mode_s || scan_out == $past(shadow_q[WIDTH-2]))
    else $error("scan_out not showing new top bit");

  AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_b)
    (diag_clk_rise && mode_s && !sin_s) |=> shadow_q == $past(pipe_q))
    else $error("shadow did not capture outputs");

  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    (diag_clk_rise && mode_s && sin_s) |=> $stable(shadow_q))
    else $error("shadow not held");

  AST_SHADOW_ONLY_DIAG_CLK: assert property (@(posedge clk) disable iff (!rst_b)
    !diag_clk_rise |=> $stable(shadow_q))
    else $error("shadow changed without diag clock");

  // pipeline path
  AST_LOAD_PINS: assert property (@(posedge clk) disable iff (!rst_b)
    (pclk_rise && !mode_s) |=> pipe_q == $past(d_sync_q))
    else $error("pipeline not loaded from pins");

  AST_LOAD_SHADOW: assert property (@(posedge clk) disable iff (!rst_b)
    (pclk_rise && mode_s) |=> pipe_q == $past(shadow_q))
    else $error("pipeline not loaded from shadow");

  AST_PIPE_ONLY_PCLK: assert property (@(posedge clk) disable iff (!rst_b)
    !pclk_rise |=> $stable(pipe_q))
    else $error("pipeline changed without pipe clock");

  AST_SWAP: assert property (@(posedge clk) disable iff (!rst_b)
    (pclk_rise && diag_clk_rise && mode_s && !sin_s)
      |=> pipe_q == $past(shadow_q) && shadow_q == $past(pipe_q))
    else $error("swap lost a prior value");

  AST_Y_OUT: assert property (@(posedge clk) disable iff (!rst_b)
    pclk_rise |=> y_out == $past(mode_s ? shadow_q : d_sync_q))
    else $error("outputs not showing loaded pipeline");

  // serial output and data pins
  AST_NO_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
    !mode_s |-> !d_oe)
    else $error("data pins driven while shifting");

  AST_CAPTURE_OE: assert property (@(posedge clk) disable iff (!rst_b)
    (mode_s && !sin_s) |-> !d_oe)
    else $error("data pins driven while capturing");

  AST_HOLD_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
    (mode_s && sin_s) |-> d_oe)
    else $error("data pins not driven while holding");

  AST_CAPTURE_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    (mode_s && !sin_s) |=> !mode_s || !scan_out)
    else $error("scan_out not low while capturing");

  AST_HOLD_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    (mode_s && sin_s) |=> !mode_s || scan_out)
    else $error("scan_out not high while holding");

  AST_SOUT_MODE: assert property (@(posedge clk) disable iff (!rst_b)
    mode_s |=> !mode_s || scan_out == $past(sin_s))
    else $error("scan_out does not follow scan_in");

  // main scenarios the bench must reach
  COV_SHIFT: cover property (@(posedge clk) disable iff (!rst_b) diag_clk_rise && !mode_s);
  COV_CAPTURE: cover property (@(posedge clk) disable iff (!rst_b) diag_clk_rise && mode_s && !sin_s);
  COV_HOLD: cover property (@(posedge clk) disable iff (!rst_b) diag_clk_rise && mode_s && sin_s);
  COV_INJECT: cover property (@(posedge clk) disable iff (!rst_b) pclk_rise && mode_s);
  COV_SWAP: cover property (@(posedge clk) disable iff (!rst_b) pclk_rise && diag_clk_rise && mode_s);
endmodule : scan_reg
`default_nettype wire

// ==== hw/scan_reg_map.svh ====
// constants for the pipeline and shadow scan register
`ifndef SCAN_REG_MAP_SVH
`define SCAN_REG_MAP_SVH
`define SCAN_WIDTH      8
`define SYNC_STAGES     2
`define DATA_RESET      8'h00
`endif

// ==== hw/scan_reg_pkg.sv ====
// types for the pipeline and shadow scan register
`default_nettype none
package scan_reg_pkg;
  typedef enum logic [3:0] {
    OP_SHIFT   = 4'h1,
    OP_CAPTURE = 4'h2,
    OP_HOLD    = 4'h4,
    OP_SPARE   = 4'h8
  } diag_op_t;
endpackage : scan_reg_pkg
`default_nettype wire

// ==== hw/edge_sync.sv ====
// two-flop synchroniser with rising-edge detect
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input  wire logic clk,    // system clock
  input  wire logic rst_b,  // async reset, active low
  input  wire logic din,    // asynchronous level
  output logic      level,  // synchronised level
  output logic      rise    // one-cycle pulse on rising edge
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
endmodule : edge_sync
`default_nettype wire

// ==== verification/diag_ctrl.sv ====
// diagnostics controller model driving the serial scan loop
`timescale 1ns/1ps
`default_nettype none
module diag_ctrl (
  output logic      diag_clk, // link clock, idle low between frames
  output logic      mode,     // mode select
  output logic      scan_in,  // serial data to device
  input  wire logic scan_out  // serial data from device
);
  initial begin
    diag_clk = 1'h0;
    mode     = 1'h0;
    scan_in  = 1'h0;
  end
  // half of the 125 ns link period, ample setup past the synchronisers
  // non-blocking, so a change that lands on a clk edge is seen after it
  task automatic set_lines(input logic m, input logic s);
    mode    <= m;
    scan_in <= s;
    #62.5;
  endtask : set_lines
  task automatic pulse();
    diag_clk <= 1'h1;
    #62.5;
    diag_clk <= 1'h0;
    #62.5;
  endtask : pulse
  // top bit first both ways, so one pass injects and observes
  task automatic shift8(input logic [7:0] v, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      set_lines(1'h0, v[i]);
      r[i] = scan_out;
      pulse();
    end
  endtask : shift8
endmodule : diag_ctrl
`default_nettype wire

// ==== verification/scan_reg_tb_top.sv ====
// self-checking bench for the pipeline and shadow scan register
`timescale 1ns/1ps
`default_nettype none
module scan_reg_tb_top;
  logic       clk, rst_b, pipe_clk, diag_clk, mode, scan_in, scan_out, d_oe;
  logic [7:0] drive_d, pins, d_out, y_out, got;
  int         failures = 0;
  int         check_count = 0;
  assign pins = d_oe ? d_out : drive_d;
  scan_reg i_scan_reg (.clk(clk), .rst_b(rst_b), .pipe_clk(pipe_clk), .diag_clk(diag_clk),
    .mode(mode), .scan_in(scan_in), .scan_out(scan_out), .d_in(pins), .d_out(d_out),
    .d_oe(d_oe), .y_out(y_out));
  diag_ctrl i_diag_ctrl (.diag_clk(diag_clk), .mode(mode), .scan_in(scan_in),
    .scan_out(scan_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic pipe_pulse();
    @(posedge clk) pipe_clk <= 1'h1;
    repeat (6) @(posedge clk);
    pipe_clk <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : pipe_pulse
  task automatic t_load();
    @(posedge clk) drive_d <= 8'hA5;
    repeat (4) @(posedge clk);
    pipe_pulse();
    check(y_out, 8'hA5, "load from pins");
    check({7'h0, d_oe}, 8'h00, "pins undriven");
    $display("load test done");
  endtask : t_load
  task automatic t_observe();
    @(posedge clk) drive_d <= 8'h5A;
    i_diag_ctrl.set_lines(1'h1, 1'h0);
    i_diag_ctrl.pulse();
    check({7'h0, scan_out}, 8'h00, "scan out in capture");
    i_diag_ctrl.shift8(8'h3C, got);
    check(got, 8'hA5, "observed pipeline");
    $display("observe test done");
  endtask : t_observe
  task automatic t_inject();
    i_diag_ctrl.set_lines(1'h1, 1'h1);
    i_diag_ctrl.pulse();
    check(pins, 8'h3C, "held shadow on pins");
    check({d_oe, scan_out, 6'h0}, 8'hC0, "hold drives pins");
    pipe_pulse();
    check(y_out, 8'h3C, "load from shadow");
    check({7'h0, scan_out}, 8'h01, "scan out follows input");
    $display("inject test done");
  endtask : t_inject
  task automatic t_swap();
    i_diag_ctrl.shift8(8'h96, got);
    check(got, 8'h3C, "shadow kept after transfer");
    i_diag_ctrl.set_lines(1'h1, 1'h0);
    @(posedge clk);
    // both edges in one time step so each side must take the prior value
    fork
      i_diag_ctrl.pulse();
      begin
        pipe_clk <= 1'h1;
        repeat (6) @(posedge clk);
        pipe_clk <= 1'h0;
      end
    join
    check(y_out, 8'h96, "swap into pipeline");
    i_diag_ctrl.shift8(8'h00, got);
    check(got, 8'h3C, "swap into shadow");
    $display("swap test done");
  endtask : t_swap
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_b    = 1'h0;
    pipe_clk = 1'h0;
    drive_d  = 8'h00;
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge clk);
    check(y_out, 8'h00, "reset value");
    t_load();
    t_observe();
    t_inject();
    t_swap();
    final_report();
  end
  // tests need about 6 us
  initial begin
    #200000;
    failures++;
    final_report();
  end
endmodule : scan_reg_tb_top
`default_nettype wire
